// *** design/sadcp_port.sv ***
// Serial control and readout port of the sampling converter
`timescale 1ns/100ps
module sadcp_port #(
  parameter bit MUX_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic                                 clock_i,
  input  wire logic                                 rst_b_i,
  // Link pins
  input  wire logic                                 select_b_i,
  input  wire logic                                 shift_clk_i,
  input  wire logic                                 data_in_i,
  output logic                                      data_out_o,
  output logic                                      data_out_oe_b_o,
  // Shared data wire mode
  input  wire logic                                 shared_wire_i,
  // Converter side
  input  wire logic [sadcp_pkg::RESULT_WIDTH-1:0]   sample_value_i,
  output logic                                      single_ended_sel_o,
  output logic                                      input_odd_sel_o,
  output logic                                      acquire_o,
  output logic                                      convert_o,
  output logic                                      powered_o,
  output logic                                      busy_o
);
  import sadcp_pkg::*;

  sadcp_sync_if sync ();

  sadcp_sync u_sync (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .select_b_i  (select_b_i),
    .shift_clk_i (shift_clk_i),
    .data_in_i   (data_in_i),
    .sync        (sync)
  );

  sadcp_state_type           state;
  sadcp_state_type           next_state;
  logic [BIT_COUNT_W-1:0]    bit_count;
  logic [BIT_COUNT_W-1:0]    next_bit_count;
  logic [CONFIG_BITS-1:0]    config_word;
  logic [CONFIG_BITS-1:0]    next_config_word;
  logic [RESULT_WIDTH-1:0]   shift_reg;
  logic [RESULT_WIDTH-1:0]   next_shift_reg;
  logic                      dout;
  logic                      next_dout;
  logic                      out_en;
  logic                      next_out_en;
  logic [3:0]                fall_count;
  logic [3:0]                next_fall_count;
  logic                      mux_sgl;
  logic                      next_mux_sgl;
  logic                      mux_odd;
  logic                      next_mux_odd;
  logic                      acquire;
  logic                      next_acquire;

  always_comb begin
    next_state       = state;
    next_bit_count   = bit_count;
    next_config_word = config_word;
    next_shift_reg   = shift_reg;
    next_dout        = dout;
    next_out_en      = out_en;
    next_fall_count  = fall_count;
    next_mux_sgl     = mux_sgl;
    next_mux_odd     = mux_odd;
    next_acquire     = acquire;
    if (sync.select_b || sync.sel_rise) begin
      next_state      = SADCP_IDLE;
      next_bit_count  = '0;
      next_dout       = 1'b0;
      next_out_en     = 1'b0;
      next_fall_count = '0;
      next_acquire    = 1'b0;
    end else if (sync.sel_fall) begin
      next_state      = MUX_VARIANT ? SADCP_START : SADCP_IDLE;
      next_bit_count  = '0;
      next_dout       = 1'b0;
      next_out_en     = 1'b0;
      next_fall_count = '0;
      if (!MUX_VARIANT) begin
        // Fixed differential pair, no input word
        next_mux_sgl = 1'b0;
        next_mux_odd = 1'b0;
      end
    end else begin
      if (sync.clk_fall && MUX_VARIANT && state != SADCP_START
          && fall_count != SHARED_DRIVE_EDGE) begin
        next_fall_count = fall_count + 4'h1;
        if (fall_count + 4'h1 == SHARED_DRIVE_EDGE && shared_wire_i) begin
          next_out_en = 1'b1;
          next_dout   = 1'b0;
        end
      end
      if (sync.clk_rise) begin
        case (state)
          SADCP_IDLE: begin
            // Three-wire variant starts its frame on the first clock
            if (!MUX_VARIANT && !out_en) begin
              next_out_en    = 1'b1;
              next_dout      = 1'b0;
              next_shift_reg = sample_value_i;
              next_bit_count = 4'h1;
              next_state     = SADCP_NULL;
            end
          end
          SADCP_START: begin
            if (sync.data_in) begin
              next_state      = SADCP_CONFIG;
              next_bit_count  = '0;
              next_fall_count = '0;
            end
          end
          SADCP_CONFIG: begin
            next_config_word = {config_word[CONFIG_BITS-2:0], sync.data_in};
            next_bit_count   = bit_count + 4'h1;
            if (bit_count == 4'h1) begin
              next_mux_sgl = config_word[0];
              next_mux_odd = sync.data_in;
              next_acquire = 1'b1;
            end
            if (bit_count == 4'(CONFIG_BITS - 1)) begin
              // Dummy bits ignored; sample taken as conversion starts
              next_state     = SADCP_NULL;
              next_acquire   = 1'b0;
              // Shared wire is taken later, on the fifth fall
              next_out_en    = ~shared_wire_i;
              next_dout      = 1'b0;
              next_shift_reg = sample_value_i;
              next_bit_count = 4'h1;
            end
          end
          SADCP_NULL: begin
            next_dout = 1'b0;
            if (bit_count == 4'(NULL_BITS)) begin
              next_state     = SADCP_RESULT;
              next_dout      = shift_reg[RESULT_WIDTH-1];
              next_shift_reg = {shift_reg[RESULT_WIDTH-2:0], 1'b0};
              next_bit_count = 4'h1;
            end else begin
              next_bit_count = bit_count + 4'h1;
            end
          end
          SADCP_RESULT: begin
            next_dout      = shift_reg[RESULT_WIDTH-1];
            next_shift_reg = {shift_reg[RESULT_WIDTH-2:0], 1'b0};
            next_bit_count = bit_count + 4'h1;
            if (bit_count == 4'(RESULT_WIDTH)) begin
              next_state = SADCP_ZEROS;
              next_dout  = 1'b0;
            end
          end
          SADCP_ZEROS: begin
            next_dout = 1'b0;
          end
          default: begin
            next_state = SADCP_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state       <= SADCP_IDLE;
      bit_count   <= '0;
      config_word <= '0;
      shift_reg   <= '0;
      dout        <= 1'b0;
      out_en      <= 1'b0;
      fall_count  <= '0;
      mux_sgl     <= 1'b0;
      mux_odd     <= 1'b0;
      acquire     <= 1'b0;
    end else begin
      state       <= next_state;
      bit_count   <= next_bit_count;
      config_word <= next_config_word;
      shift_reg   <= next_shift_reg;
      dout        <= next_dout;
      out_en      <= next_out_en;
      fall_count  <= next_fall_count;
      mux_sgl     <= next_mux_sgl;
      mux_odd     <= next_mux_odd;
      acquire     <= next_acquire;
    end
  end

  assign data_out_o         = dout;
  assign data_out_oe_b_o    = ~out_en;
  assign single_ended_sel_o = mux_sgl;
  assign input_odd_sel_o    = mux_odd;
  assign acquire_o          = acquire;
  assign convert_o          = (state == SADCP_NULL) || (state == SADCP_RESULT);
  assign busy_o             = ~sync.select_b;
  // Powered only while acquiring or converting in the multiplexed variant
  assign powered_o          = MUX_VARIANT ?
                              (~sync.select_b & (acquire | convert_o)) :
                              ~sync.select_b;

endmodule // sadcp_port

// *** design/sadcp_pkg.sv ***
// Package of constants and types for the serial converter port
// Overview of operation
// - Device is active only while select is low; ignores interface otherwise.
// - Multiplexed variant powers down when select high or neither acquiring nor converting.
// - Each falling edge of select starts a new exchange.
// - Three-wire variant: output off after select falls, enabled on first clock.
// - Two null bits are driven before the result bits.
// - The result is eight bits wide.
// - Result goes out MSB first, then zeros while clocks continue.
// - Raising select resets the serial port state.
// - Multiplexed variant samples input bits on rising shift clock.
// - Output bits update on rising shift clock.
// - Input zeros before the first one are ignored; that one is start.
// - After start, exactly four configuration bits are shifted in.
// - First two configuration bits set the multiplexer.
// - Last two configuration bits give two clocks of acquisition.
// - Further input is ignored until select goes high and low again.
// - Three-wire variant needs no input; fixed differential pair.
// - Mux bits: 10 input a, 11 input b, 00 a minus b, 01 b minus a.
// - Either value is accepted for the two dummy bits.
// - On a shared wire, device drives low on fifth falling edge after start.
package sadcp_pkg;

  localparam int RESULT_WIDTH   = 8;
  localparam int CONFIG_BITS    = 4;
  localparam int NULL_BITS      = 2;
  localparam int BIT_COUNT_W    = 4;
  // Falling edges after start bit at which shared line is taken
  localparam logic [3:0] SHARED_DRIVE_EDGE = 4'h5;

  typedef enum logic [2:0] {
    SADCP_IDLE    = 3'b000,
    SADCP_START   = 3'b001,
    SADCP_CONFIG  = 3'b010,
    SADCP_NULL    = 3'b011,
    SADCP_RESULT  = 3'b100,
    SADCP_ZEROS   = 3'b101
  } sadcp_state_type;

  typedef enum logic [1:0] {
    SADCP_DIFF_A_B = 2'b00,
    SADCP_DIFF_B_A = 2'b01,
    SADCP_SGL_A    = 2'b10,
    SADCP_SGL_B    = 2'b11
  } sadcp_mux_type;

endpackage

// *** design/sadcp_sync_if.sv ***
// Interface carrying synchronised link levels and their edges
`timescale 1ns/100ps
interface sadcp_sync_if;
  logic select_b;
  logic shift_clk;
  logic data_in;
  logic clk_rise;
  logic clk_fall;
  logic sel_fall;
  logic sel_rise;
  modport src (output select_b, shift_clk, data_in, clk_rise, clk_fall,
               output sel_fall, sel_rise);
  modport dst (input select_b, shift_clk, data_in, clk_rise, clk_fall,
               input sel_fall, sel_rise);
endinterface

// *** design/sadcp_sync.sv ***
// Two-stage synchronisers and edge finders for the link pins
`timescale 1ns/100ps
module sadcp_sync (
  // Clock and reset
  input  wire logic   clock_i,
  input  wire logic   rst_b_i,
  // Raw pins
  input  wire logic   select_b_i,
  input  wire logic   shift_clk_i,
  input  wire logic   data_in_i,
  // Synchronised side
  sadcp_sync_if.src   sync
);
  import sadcp_pkg::*;

  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] delayed;
  logic [2:0] next_stage1;
  logic [2:0] next_stage2;
  logic [2:0] next_delayed;

  always_comb begin
    next_stage1  = {select_b_i, shift_clk_i, data_in_i};
    next_stage2  = stage1;
    next_delayed = stage2;
  end

  // Select idles high so the port starts disabled
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1  <= 3'h4;
      stage2  <= 3'h4;
      delayed <= 3'h4;
    end else begin
      stage1  <= next_stage1;
      stage2  <= next_stage2;
      delayed <= next_delayed;
    end
  end

  assign sync.select_b  = stage2[2];
  assign sync.shift_clk = stage2[1];
  assign sync.data_in   = stage2[0];
  assign sync.clk_rise  = stage2[1] & ~delayed[1];
  assign sync.clk_fall  = ~stage2[1] & delayed[1];
  assign sync.sel_fall  = ~stage2[2] & delayed[2];
  assign sync.sel_rise  = stage2[2] & ~delayed[2];

endmodule // sadcp_sync

// *** test/sadcp_props.sv ***
// Pin-level checks of the serial converter port
`timescale 1ns/100ps
module sadcp_props #(
  parameter bit MUX_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Watched ports
  input wire logic select_b_i,
  input wire logic shift_clk_i,
  input wire logic shared_wire_i,
  input wire logic data_out_o,
  input wire logic data_out_oe_b_o,
  input wire logic acquire_o,
  input wire logic convert_o,
  input wire logic powered_o,
  input wire logic busy_o
);
  logic [5:0] sck_q, next_sck_q;
  logic [4:0] sel_q, next_sel_q, n_rise, next_n_rise;
  logic       rise_win, fall_win;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Shift clock edge seen two to four cycles back
  assign rise_win = |(sck_q[3:1] & ~sck_q[4:2]);
  assign fall_win = |(~sck_q[3:1] & sck_q[4:2]);
  always_comb begin
    next_sck_q  = {sck_q[4:0], shift_clk_i};
    next_sel_q  = {sel_q[3:0], select_b_i};
    next_n_rise = n_rise;
    if (data_out_oe_b_o) next_n_rise = 5'h00;
    else if (shift_clk_i && !sck_q[0] && !n_rise[4]) next_n_rise = n_rise + 5'h01;
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_q  <= 6'h00;
      sel_q  <= 5'h1F;
      n_rise <= 5'h00;
    end else begin
      sck_q  <= next_sck_q;
      sel_q  <= next_sel_q;
      n_rise <= next_n_rise;
    end
  end
  sequence s_acq_hold; acquire_o [*8]; endsequence
  sequence s_to_conv; ##[1:12] !acquire_o ##[0:3] convert_o; endsequence
  property p_idle; select_b_i [*5] |-> data_out_oe_b_o && !busy_o; endproperty
  property p_busy; $fell(select_b_i) |-> ##[1:4] busy_o; endproperty
  property p_power;
    MUX_VARIANT && powered_o |->
      acquire_o || convert_o || $past(acquire_o || convert_o);
  endproperty
  property p_update;
    $changed(data_out_o) && !data_out_oe_b_o && !$past(data_out_oe_b_o) |-> rise_win;
  endproperty
  property p_enable; $fell(data_out_oe_b_o) |-> (shared_wire_i ? fall_win : rise_win); endproperty
  property p_null; !data_out_oe_b_o && n_rise < 5'h02 |-> !data_out_o; endproperty
  property p_zeros; n_rise > 5'h0A |-> !data_out_o; endproperty
  property p_oe_hold; $rose(data_out_oe_b_o) |-> |sel_q[4:1]; endproperty
  property p_acquire; $rose(acquire_o) |-> s_acq_hold ##0 s_to_conv; endproperty
  a_idle: assert property (p_idle) else $error("port active while deselected");
  a_busy: assert property (p_busy) else $error("select fall not taken");
  a_power: assert property (p_power) else $error("powered outside conversion");
  a_update: assert property (p_update) else $error("output moved off clock rise");
  a_enable: assert property (p_enable) else $error("output enabled off edge");
  a_null: assert property (p_null) else $error("null bit not low");
  a_zeros: assert property (p_zeros) else $error("tail bit not low");
  a_oe_hold: assert property (p_oe_hold) else $error("output off while selected");
  a_acquire: assert property (p_acquire) else $error("acquire span wrong");
endmodule // sadcp_props
bind sadcp_port sadcp_props #(.MUX_VARIANT(MUX_VARIANT)) props_u (
  .clock_i, .rst_b_i, .select_b_i, .shift_clk_i, .shared_wire_i,
  .data_out_o, .data_out_oe_b_o, .acquire_o, .convert_o, .powered_o, .busy_o
);

// *** test/sadcp_host.sv ***
// Host serial port model driving select, shift clock and input word
`timescale 1ns/100ps
module sadcp_host (
  // Clock
  input  wire logic clock_i,
  // Link pins
  input  wire logic data_out_i,
  output logic      select_b_o,
  output logic      shift_clk_o,
  output logic      data_in_o
);
  initial begin
    select_b_o  = 1'b1;
    shift_clk_o = 1'b0;
    data_in_o   = 1'b0;
  end
  // Half of an 800 ns shift clock period, below full conversion rate
  task automatic half();
    repeat (4) @(posedge clock_i);
  endtask
  task automatic exchange(input int lead, input logic [3:0] cfg, input int n,
                          output logic [31:0] cap);
    cap = 32'h0;
    select_b_o <= 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      // Idle zeros, start, word, then released line toggles
      data_in_o <= (i < lead) ? 1'b0 : (i == lead) ? 1'b1 :
                   (i <= lead + 4) ? cfg[lead + 4 - i] : ~data_in_o;
      half();
      cap = {cap[30:0], data_out_i};
      shift_clk_o <= 1'b1;
      half();
      shift_clk_o <= 1'b0;
    end
  endtask
  task automatic stop();
    half();
    select_b_o <= 1'b1;
    data_in_o  <= 1'b0;
    half();
    half();
  endtask
endmodule // sadcp_host

// *** test/test_serial_adc_port.sv ***
// Self-checking bench for the serial converter port
`timescale 1ns/100ps
module test_serial_adc_port;
  import sadcp_pkg::*;
  logic                    clock_i = 1'b0;
  logic                    rst_b_i = 1'b0;
  logic                    shared  = 1'b0;
  logic [RESULT_WIDTH-1:0] sample  = 8'h00;
  logic sel_m, sck_m, din_m, dout_m, oe_m, se, odd, pwr, busy;
  logic sel_w, sck_w, din_w, dout_w, oe_w;
  logic [31:0] cap;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // Lead zeros, word, sample, expected mode and channel
  logic [17:0] rows [4] = '{{4'h0, 4'hA, 8'hA5, 2'h2}, {4'h2, 4'hF, 8'h81, 2'h3},
                            {4'h1, 4'h3, 8'hFF, 2'h0}, {4'h3, 4'h4, 8'h01, 2'h1}};
  always #50 clock_i = ~clock_i;
  sadcp_port #(.MUX_VARIANT(1'b1)) dut_u (.clock_i, .rst_b_i, .select_b_i(sel_m),
    .shift_clk_i(sck_m), .data_in_i(din_m), .data_out_o(dout_m),
    .data_out_oe_b_o(oe_m), .shared_wire_i(shared), .sample_value_i(sample),
    .single_ended_sel_o(se), .input_odd_sel_o(odd), .acquire_o(), .convert_o(),
    .powered_o(pwr), .busy_o(busy));
  sadcp_port #(.MUX_VARIANT(1'b0)) dut_w (.clock_i, .rst_b_i, .select_b_i(sel_w),
    .shift_clk_i(sck_w), .data_in_i(din_w), .data_out_o(dout_w),
    .data_out_oe_b_o(oe_w), .shared_wire_i(1'b0), .sample_value_i(sample),
    .single_ended_sel_o(), .input_odd_sel_o(), .acquire_o(), .convert_o(),
    .powered_o(), .busy_o());
  // Released line reads inverted, so a late output enable is caught
  sadcp_host host_m (.clock_i, .data_out_i(dout_m ^ oe_m), .select_b_o(sel_m),
    .shift_clk_o(sck_m), .data_in_o(din_m));
  sadcp_host host_w (.clock_i, .data_out_i(dout_w ^ oe_w), .select_b_o(sel_w),
    .shift_clk_o(sck_w), .data_in_o(din_w));
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Traffic needs about 1100 cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge clock_i);
    check_bit(oe_m, 1'b1);
    check_bit(dout_m | busy | pwr, 1'b0);
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    foreach (rows[r]) begin
      sample <= rows[r][9:2];
      host_m.exchange(rows[r][17:14], rows[r][13:10], rows[r][17:14] + 16, cap);
      check_word(cap[10:0], {2'b00, rows[r][9:2], 1'b0});
      check_bit(se, rows[r][1]);
      check_bit(odd, rows[r][0]);
      check_bit(oe_m, 1'b0);
      host_m.stop();
      check_bit(oe_m, 1'b1);
      check_bit(pwr, 1'b0);
    end
    // Exchange cut short in the word, then a full one
    sample <= 8'h3C;
    host_m.exchange(0, 4'hE, 2, cap);
    host_m.stop();
    host_m.exchange(0, 4'hE, 16, cap);
    check_word(cap[10:0], {2'b00, 8'h3C, 1'b0});
    check_bit(se & odd, 1'b1);
    host_m.stop();
    shared <= 1'b1;
    sample <= 8'hC3;
    host_m.exchange(1, 4'hB, 17, cap);
    check_word(cap[10:0], {2'b00, 8'hC3, 1'b0});
    host_m.stop();
    shared <= 1'b0;
    sample <= 8'h5C;
    host_w.exchange(0, 4'h0, 12, cap);
    check_word(cap[10:0], {2'b00, 8'h5C, 1'b0});
    host_w.stop();
    check_bit(oe_w, 1'b1);
    finish_test();
  end
endmodule // test_serial_adc_port
